// ---- chan_cfg_consts.svh ----
`ifndef CHAN_CFG_CONSTS_SVH
`define CHAN_CFG_CONSTS_SVH
// ==========================================
// address map (register field codes on avs_address[3:2])
`define HALF_MEM 2'h0
`define HALF_IO 2'h1
`define HALF_CNT 2'h2
`define HALF_CTL 2'h3
`define GRP_HIGH 2'h0
`define GRP_LOW 2'h1
`define GRP_STAT 2'h2
// ==========================================
// channel_control fields
`define CTL_SIZE 7
`define CTL_DEC 6
`define CTL_RPT 5
`define CTL_DIR 4
`define CTL_SINGLE 3
`define CTL_IDLE 2
`define CTL_RST 16'h0000
// ==========================================
// group_control_high fields
`define GRP_MSTOP 2
`define FAE_RST 2'h0
`define MSTOP_RST 1'b1
// ==========================================
// address forming
`define IO_HIGH 8'hff
`define STEP_BYTE 24'h000001
`define STEP_WORD 24'h000002
`define INT_SRC_DEF 11
`endif

// ---- chan_cfg_pkg.sv ----
package chan_cfg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_UPD = 4'b1000
  } state_t;
  typedef enum logic [1:0] {
    SRC_AUTO = 2'h0,
    SRC_EXT = 2'h1,
    SRC_INT = 2'h2,
    SRC_OFF = 2'h3
  } act_src_t;
endpackage

// ---- transfer_controller.sv ----
// What this block does
// - short mode gives up to four independent half channels A and B.
// - full mode gives at most two channels, each joining halves A and B.
// - short dual transfers use a 24-bit memory side and a 16-bit io side.
// - single-address transfers use one 24-bit address and one bus cycle.
// - short channels run sequential, idle or repeat variants.
// - full mode uses 24-bit source and destination, normal or block.
// - 16-Mbyte direct addressing; unit is byte or 16-bit word.
// - start by internal event, external request or auto-request.
// - internal sources: six timer events, four serial events, converter end.
// - per pair a request input, acknowledge output and end output.
// - full-address enable bit per pair: 0 independent, 1 combined.
// - each short half has memory, io, counter and control registers.
// - full mode: A counter counts transfers, B counts blocks; io unused.
// - memory pointer 32 bits in two halves; top 8 bits read zero.
// - memory pointers are not touched by reset or standby.
// - short mode direction bit makes memory pointer source or destination.
// - full mode A pointer is source, B pointer is destination.
// - memory pointer steps after every byte or word transferred, except in idle mode or on a repeat restore.
// - module-stop setting halts the controller.
// - io address is ff in upper 8 bits and never steps.
// - pointer step is 1 for bytes and 2 for words.
// - counter decrements per transfer; outside repeat and block modes, at zero enable clears and run ends.
`timescale 1ns/1ps
`include "chan_cfg_consts.svh"

module transfer_controller #(
  parameter int INT_SRC = `INT_SRC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // external pins
  input wire logic xfer_request_in_0,
  input wire logic xfer_request_in_1,
  output logic xfer_acknowledge_out_0,
  output logic xfer_acknowledge_out_1,
  output logic xfer_end_out_0,
  output logic xfer_end_out_1,
  // internal activation events
  input wire logic [INT_SRC-1:0] int_evt,
  // bus arbiter side
  output logic xfer_req,
  output logic [23:0] xfer_src_addr,
  output logic [23:0] xfer_dst_addr,
  output logic xfer_word,
  output logic xfer_single,
  input wire logic xfer_done
);
  import chan_cfg_pkg::*;

  if (INT_SRC < 1 || INT_SRC > 15) begin : g_chk
    $error("INT_SRC must be 1 to 15");
  end

  // ==========================================
  // storage
  logic [23:0] mar_q [4];
  logic [23:0] mar_start_q [4];
  logic [15:0] io_q [4];
  logic [15:0] cnt_q [4];
  logic [15:0] ctl_q [4];
  logic [1:0] fae_q;
  logic mstop_q;
  logic [3:0] en_q;
  logic [3:0] pend_q;
  logic [3:0] trig;
  state_t state_q;
  logic [1:0] cur_q;
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic req_q;
  logic [23:0] src_q;
  logic [23:0] dst_q;
  logic word_q;
  logic single_q;
  logic [1:0] ack_q;
  logic [1:0] end_q;

  // ==========================================
  // bus slave
  logic wr_go;
  logic rd_go;
  logic grp_sel;
  logic [1:0] hidx;
  logic [1:0] fld;
  logic lo_en;
  logic hi_en;
  assign wr_go = avs_write & ~waitreq_q;
  assign rd_go = avs_read & waitreq_q;
  assign grp_sel = avs_address[6];
  assign hidx = avs_address[5:4];
  assign fld = avs_address[3:2];
  assign lo_en = |avs_byteenable[1:0];
  assign hi_en = |avs_byteenable[3:2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= ~((avs_read | avs_write) & waitreq_q);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
    end else if (rd_go) begin
      rdata_q <= 32'h0;
      if (!grp_sel) begin
        case (fld)
          `HALF_MEM: rdata_q <= {8'h00, mar_q[hidx]};
          `HALF_IO: rdata_q <= {16'h0, io_q[hidx]};
          `HALF_CNT: rdata_q <= {16'h0, cnt_q[hidx]};
          default: rdata_q <= {16'h0, ctl_q[hidx]};
        endcase
      end else if (hidx == 2'h0) begin
        case (fld)
          `GRP_HIGH: rdata_q <= {29'h0, mstop_q, fae_q};
          `GRP_LOW: rdata_q <= {28'h0, en_q};
          `GRP_STAT: rdata_q <= {26'h0, pend_q, cur_q};
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================
  // group control
  logic grp_wr;
  assign grp_wr = wr_go & grp_sel & (hidx == 2'h0) & lo_en;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fae_q <= `FAE_RST;
      mstop_q <= `MSTOP_RST;
    end else if (grp_wr && fld == `GRP_HIGH) begin
      fae_q <= avs_writedata[1:0];
      mstop_q <= avs_writedata[`GRP_MSTOP];
    end
  end

  // ==========================================
  // current half decode
  act_src_t c_src;
  logic [15:0] c_ctl;
  logic c_full;
  logic [1:0] partner;
  logic [23:0] step;
  logic [23:0] io_addr;
  logic rpt;
  logic blk;
  logic idle_md;
  logic [15:0] cnt;
  logic [7:0] lo_m1;
  logic wrap;
  logic [15:0] cnt_new;
  logic [15:0] blk_new;
  logic fin;
  logic restore;
  logic upd;

  assign c_ctl = ctl_q[cur_q];
  assign c_src = act_src_t'(c_ctl[1:0]);
  assign c_full = fae_q[cur_q[1]];
  assign partner = {cur_q[1], 1'b1};
  assign step = c_ctl[`CTL_SIZE] ? `STEP_WORD : `STEP_BYTE;
  assign io_addr = {`IO_HIGH, io_q[cur_q]};
  assign rpt = ~c_full & c_ctl[`CTL_RPT];
  assign idle_md = ~c_full & c_ctl[`CTL_IDLE] & ~rpt;
  assign blk = c_full & c_ctl[`CTL_RPT];
  assign upd = state_q == ST_UPD;
  assign cnt = cnt_q[cur_q];
  assign lo_m1 = cnt[7:0] - 8'h01;
  assign wrap = lo_m1 == 8'h00;
  assign blk_new = cnt_q[partner] - 16'h0001;
  assign restore = rpt & wrap;

  always_comb begin
    if (rpt || blk) begin
      cnt_new = wrap ? {cnt[15:8], cnt[15:8]} : {cnt[15:8], lo_m1};
      fin = blk & wrap & (blk_new == 16'h0000);
    end else begin
      cnt_new = cnt - 16'h0001;
      fin = cnt_new == 16'h0000;
    end
  end

  // ==========================================
  // per half registers and triggers
  logic [15:0] evt_pad;
  logic [1:0] ext_req;
  assign evt_pad = 16'(int_evt);
  assign ext_req = {xfer_request_in_1, xfer_request_in_0};

  for (genvar h = 0; h < 4; h++) begin : g_half
    logic wr_h;
    logic live;
    logic hit;
    logic mine;
    act_src_t src;
    assign wr_h = wr_go & ~grp_sel & (hidx == 2'(h));
    assign src = act_src_t'(ctl_q[h][1:0]);
    assign live = en_q[h] & ~(fae_q[h / 2] & (h % 2 == 1));
    assign hit = evt_pad[ctl_q[h][11:8]] & (ctl_q[h][11:8] < 4'(INT_SRC));
    assign mine = upd & ((cur_q == 2'(h)) | (c_full & (partner == 2'(h))));
    assign trig[h] = live & ((src == SRC_AUTO) |
                             ((src == SRC_EXT) & ext_req[h / 2]) |
                             ((src == SRC_INT) & pend_q[h]));

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pend_q[h] <= 1'b0;
      end else begin
        pend_q[h] <= (pend_q[h] & ~(upd & (cur_q == 2'(h)))) | hit;
      end
    end

    // pointer, io and counter keep contents through reset
    always_ff @(posedge clk) begin
      if (wr_h && fld == `HALF_MEM) begin
        if (lo_en) begin
          mar_q[h][15:0] <= avs_writedata[15:0];
          mar_start_q[h][15:0] <= avs_writedata[15:0];
        end
        if (hi_en) begin
          mar_q[h][23:16] <= avs_writedata[23:16];
          mar_start_q[h][23:16] <= avs_writedata[23:16];
        end
      end else if (mine) begin
        if (restore) begin
          mar_q[h] <= mar_start_q[h];
        end else if (!idle_md) begin
          mar_q[h] <= c_ctl[`CTL_DEC] ? mar_q[h] - step : mar_q[h] + step;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (wr_h && fld == `HALF_IO && lo_en) begin
        io_q[h] <= avs_writedata[15:0];
      end
    end

    always_ff @(posedge clk) begin
      if (wr_h && fld == `HALF_CNT && lo_en) begin
        cnt_q[h] <= avs_writedata[15:0];
      end else if (upd && cur_q == 2'(h)) begin
        cnt_q[h] <= cnt_new;
      end else if (upd && blk && wrap && partner == 2'(h)) begin
        cnt_q[h] <= blk_new;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ctl_q[h] <= `CTL_RST;
      end else if (wr_h && fld == `HALF_CTL && lo_en) begin
        ctl_q[h] <= avs_writedata[15:0];
      end
    end
  end

  // enable cleared at end of run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q <= 4'h0;
    end else if (grp_wr && fld == `GRP_LOW) begin
      en_q <= avs_writedata[3:0];
    end else if (upd && fin) begin
      en_q[cur_q] <= 1'b0;
    end
  end

  // ==========================================
  // sequencer
  logic [1:0] pick;
  always_comb begin
    pick = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (trig[i]) begin
        pick = 2'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cur_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (!mstop_q && |trig) begin
            cur_q <= pick;
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (xfer_done) begin
            state_q <= ST_UPD;
          end
        end
        ST_UPD: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_q <= 1'b0;
      src_q <= 24'h0;
      dst_q <= 24'h0;
      word_q <= 1'b0;
      single_q <= 1'b0;
    end else if (state_q == ST_LOAD) begin
      req_q <= 1'b1;
      // byte or word unit on 24-bit space
      word_q <= c_ctl[`CTL_SIZE];
      single_q <= ~c_full & c_ctl[`CTL_SINGLE];
      if (c_full) begin
        src_q <= mar_q[cur_q];
        dst_q <= mar_q[partner];
      end else if (c_ctl[`CTL_SINGLE]) begin
        src_q <= mar_q[cur_q];
        dst_q <= mar_q[cur_q];
      end else if (c_ctl[`CTL_DIR]) begin
        src_q <= io_addr;
        dst_q <= mar_q[cur_q];
      end else begin
        src_q <= mar_q[cur_q];
        dst_q <= io_addr;
      end
    end else if (state_q == ST_WAIT && xfer_done) begin
      req_q <= 1'b0;
    end
  end

  // acknowledge and end pins per pair
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 2'h0;
      end_q <= 2'h0;
    end else begin
      ack_q <= 2'h0;
      end_q <= 2'h0;
      if (state_q == ST_LOAD && !c_full && c_ctl[`CTL_SINGLE]) begin
        ack_q[cur_q[1]] <= 1'b1;
      end else if (state_q == ST_WAIT && !xfer_done) begin
        ack_q <= ack_q;
      end
      if (upd && fin) begin
        end_q[cur_q[1]] <= 1'b1;
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign xfer_req = req_q;
  assign xfer_src_addr = src_q;
  assign xfer_dst_addr = dst_q;
  assign xfer_word = word_q;
  assign xfer_single = single_q;
  assign xfer_acknowledge_out_0 = ack_q[0];
  assign xfer_acknowledge_out_1 = ack_q[1];
  assign xfer_end_out_0 = end_q[0];
  assign xfer_end_out_1 = end_q[1];

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_load;
    state_q == ST_LOAD;
  endsequence
  sequence s_done;
    state_q == ST_WAIT && xfer_done;
  endsequence

  a_ack_single: assert property (xfer_req && xfer_single |-> (ack_q != 2'h0))
    else $error("acknowledge missing on single transfer");
  a_io_upper: assert property (s_load ##1 (xfer_req && !xfer_single &&
      !c_full) |-> (src_q[23:16] == 8'hff) || (dst_q[23:16] == 8'hff))
    else $error("io side upper byte not ff");
  a_full_roles: assert property ((s_load and c_full) |=> (src_q == $past(mar_q[cur_q]))
      && (dst_q == $past(mar_q[partner])))
    else $error("full mode address roles wrong");
  a_word_step: assert property (s_done ##1 (upd && !c_full && !idle_md && !restore
      && c_ctl[`CTL_SIZE]) |=>
      mar_q[$past(cur_q)] == $past(mar_q[cur_q]) +
      ($past(c_ctl[`CTL_DEC]) ? 24'hfffffe : 24'h000002))
    else $error("word step not two");
  a_end_clear: assert property (upd && fin && !(grp_wr && fld == `GRP_LOW) |=>
      !en_q[$past(cur_q)] && (end_q != 2'h0))
    else $error("run end did not clear enable");
  a_stop_hold: assert property (mstop_q && state_q == ST_IDLE |=> state_q == ST_IDLE)
    else $error("stopped module started");
  a_mar_top: assert property (rd_go && !grp_sel && fld == `HALF_MEM |=>
      avs_readdata[31:24] == 8'h00)
    else $error("pointer top byte not zero");
  a_bus_answer: assert property ((avs_read || avs_write) && waitreq_q |=> !avs_waitrequest
      ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  a_req_hold: assert property (xfer_req && !xfer_done |=> xfer_req && $stable(src_q))
    else $error("request dropped early");
endmodule

// ---- bus_responder.sv ----
`timescale 1ns/1ps
module bus_responder (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request side
  input wire logic xfer_req,
  input wire logic [3:0] lat,
  // completion
  output logic xfer_done
);
  logic [3:0] wait_q;
  // ==========
  // completion after lat idle cycles, one-cycle pulse
  always_ff @(posedge clk) begin
    if (sys_rst || !xfer_req || xfer_done) begin
      wait_q <= 4'h0;
      xfer_done <= 1'b0;
    end else if (wait_q >= lat) begin
      xfer_done <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ---- transfer_controller_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module transfer_controller_tb;
  // ==========
  // signals
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, lat;
  logic req0, req1, ack0, ack1, end0, end1;
  logic [10:0] int_evt;
  logic xfer_req, xfer_word, xfer_single, xfer_done;
  logic [23:0] xfer_src_addr, xfer_dst_addr;
  logic [23:0] src_q[$], dst_q[$];
  logic [3:0] flg_q[$];
  int fails, cmp_count, ec0, ec1;

  transfer_controller u_dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .xfer_request_in_0(req0), .xfer_request_in_1(req1),
    .xfer_acknowledge_out_0(ack0), .xfer_acknowledge_out_1(ack1),
    .xfer_end_out_0(end0), .xfer_end_out_1(end1), .int_evt(int_evt),
    .xfer_req(xfer_req), .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
    .xfer_word(xfer_word), .xfer_single(xfer_single), .xfer_done(xfer_done)
  );
  bus_responder u_arb (
    .clk(clk), .sys_rst(sys_rst), .xfer_req(xfer_req), .lat(lat), .xfer_done(xfer_done)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========
  // monitor: one entry per completed transfer
  always @(posedge clk) begin
    if (xfer_req === 1'b1 && xfer_done === 1'b1) begin
      src_q.push_back(xfer_src_addr);
      dst_q.push_back(xfer_dst_addr);
      flg_q.push_back({xfer_single, xfer_word, ack1, ack0});
    end
    if (end0 === 1'b1) ec0++;
    if (end1 === 1'b1) ec1++;
  end

  // ==========
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo(input string n);
    fails++;
    $display("CHECK FAILED %s exp done got timeout", n);
    end_of_test();
  endtask
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50) tmo("bus");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic chk_rd(input string n, input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(n, e, rd)
  endtask
  task automatic cfg(input int h, input logic [31:0] m, input logic [15:0] c,
                     input logic [15:0] ctl);
    wr(7'(h * 16), m);
    wr(7'(h * 16 + 4), 32'h0040);
    wr(7'(h * 16 + 8), {16'h0, c});
    wr(7'(h * 16 + 12), {16'h0, ctl});
  endtask
  task automatic clr();
    src_q.delete();
    dst_q.delete();
    flg_q.delete();
    ec0 = 0;
    ec1 = 0;
  endtask
  task automatic wait_n(input int n);
    int k;
    k = 0;
    while (src_q.size() < n && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (k >= 300) tmo("transfers");
    repeat (8) @(posedge clk);
  endtask

  // ==========
  // scenarios
  task automatic t_regs();
    chk_rd("group high", 7'h40, 32'h4);
    chk_rd("group low", 7'h44, 32'h0);
    chk_rd("control", 7'h0c, 32'h0);
    wr(7'h00, 32'hab12_3456);
    chk_rd("pointer", 7'h00, 32'h0012_3456);
    bus(1'b1, 7'h00, 32'h0099_9999, 4'h3);
    chk_rd("low half", 7'h00, 32'h0012_9999);
    chk_rd("unmapped", 7'h7c, 32'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_rd("kept", 7'h00, 32'h0012_9999);
    $display("regs done");
  endtask
  task automatic t_stop();
    clr();
    cfg(3, 32'h5000, 16'h1, 16'h0);
    wr(7'h44, 32'h8);
    repeat (30) @(posedge clk);
    `CHK("stopped", 0, src_q.size())
    wr(7'h40, 32'h0);
    wait_n(1);
    `CHK("resumed", 24'h5000, src_q[0])
    $display("stop done");
  endtask
  task automatic t_short();
    logic [15:0] ctl[4] = '{16'h0000, 16'h0004, 16'h00d0, 16'h0020};
    logic [15:0] cnt[4] = '{16'h3, 16'h3, 16'h3, 16'h0202};
    int st[4] = '{1, 0, -2, 1};
    logic [23:0] m;
    logic [3:0] fl;
    for (int v = 0; v < 4; v++) begin
      clr();
      lat <= 4'(2 * v);
      cfg(0, 32'h1000, cnt[v], ctl[v]);
      wr(7'h44, 32'h1);
      wait_n(3);
      if (v == 3) wr(7'h44, 32'h0);
      repeat (20) @(posedge clk);
      fl = {1'b0, ctl[v][7], 2'b00};
      for (int k = 0; k < 3; k++) begin
        m = 24'h1000 + 24'(st[v] * ((v == 3) ? k % 2 : k));
        `CHK("source", ctl[v][4] ? 24'hff0040 : m, src_q[k])
        `CHK("dest", ctl[v][4] ? m : 24'hff0040, dst_q[k])
        `CHK("flags", fl, flg_q[k])
      end
      if (v < 3) begin
        `CHK("runs", 3, src_q.size())
        `CHK("ends", 1, ec0)
        chk_rd("stepped", 7'h00, 32'h1000 + 32'(st[v] * 3));
      end
    end
    $display("short done");
  endtask
  task automatic t_halves();
    clr();
    lat <= 4'h1;
    for (int h = 0; h < 4; h++) cfg(h, 32'h200000 + 32'(h << 16), 16'h1, 16'h0);
    wr(7'h44, 32'hf);
    wait_n(4);
    for (int h = 0; h < 4; h++) `CHK("half", 24'h200000 + 24'(h << 16), src_q[h])
    `CHK("pair0 ends", 2, ec0)
    `CHK("pair1 ends", 2, ec1)
    $display("halves done");
  endtask
  task automatic t_full();
    clr();
    wr(7'h40, 32'h1);
    cfg(0, 32'h123456, 16'h2, 16'h0080);
    cfg(1, 32'h654320, 16'h1, 16'h0);
    wr(7'h44, 32'h3);
    wait_n(2);
    `CHK("count", 2, src_q.size())
    for (int k = 0; k < 2; k++) begin
      `CHK("full src", 24'h123456 + 24'(2 * k), src_q[k])
      `CHK("full dst", 24'h654320 + 24'(2 * k), dst_q[k])
      `CHK("word", 4'b0100, flg_q[k])
    end
    cfg(0, 32'h1000, 16'h0202, 16'h0020);
    cfg(1, 32'h2000, 16'h2, 16'h0);
    clr();
    wr(7'h44, 32'h1);
    wait_n(4);
    `CHK("blocks", 4, src_q.size())
    `CHK("block end", 1, ec0)
    `CHK("block src", 24'h1003, src_q[3])
    `CHK("block dst", 24'h2003, dst_q[3])
    chk_rd("block count", 7'h18, 32'h0);
    wr(7'h44, 32'h0);
    wr(7'h40, 32'h0);
    $display("full done");
  endtask
  task automatic t_ext();
    clr();
    cfg(2, 32'h3000, 16'h2, 16'h0009);
    wr(7'h44, 32'h4);
    repeat (20) @(posedge clk);
    `CHK("no request", 0, src_q.size())
    req1 <= 1'b1;
    wait_n(2);
    req1 <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      `CHK("single src", 24'h3000 + 24'(k), src_q[k])
      `CHK("single dst", 24'h3000 + 24'(k), dst_q[k])
      `CHK("acknowledge", 4'b1010, flg_q[k])
    end
    `CHK("pair1 end", 1, ec1)
    `CHK("ack low", 1'b0, ack1)
    $display("external done");
  endtask
  task automatic t_int();
    for (int i = 0; i < 11; i++) begin
      clr();
      cfg(1, 32'h4000, 16'h1, 16'(i << 8) | 16'h0002);
      wr(7'h44, 32'h2);
      int_evt <= 11'h1 << ((i + 1) % 11);
      @(posedge clk);
      int_evt <= 11'h0;
      repeat (10) @(posedge clk);
      `CHK("other event", 0, src_q.size())
      int_evt <= 11'h1 << i;
      @(posedge clk);
      int_evt <= 11'h0;
      wait_n(1);
      `CHK("event start", 24'h4000, src_q[0])
    end
    $display("internal done");
  endtask

  initial begin
    fails = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 7'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    lat = 4'h0;
    req0 = 1'b0;
    req1 = 1'b0;
    int_evt = 11'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_stop();
    t_short();
    t_halves();
    t_full();
    t_ext();
    t_int();
    end_of_test();
  end
endmodule
